// ==== rtl/usb_dma_map.svh ====
// Register offsets, field positions and fixed values of the packet DMA block.
`ifndef USB_DMA_MAP_SVH
`define USB_DMA_MAP_SVH

`define A_SCHED_CTRL   12'h000
`define A_CH_EN        12'h004
`define A_STATUS       12'h008
`define A_PROBE        12'h00C
`define A_DESC_ADDR    12'h010
`define A_LINK_ADDR    12'h014
`define A_LINK_BASE0   12'h018
`define A_LINK_BASE1   12'h01C
`define A_LINK0_COUNT  12'h020
`define A_REGION       12'h100
`define A_REGION_END   12'h17F
`define A_TXREC        12'h200
`define A_TXREC_END    12'h27F
`define A_RXREC        12'h300
`define A_RXREC_END    12'h33F
`define A_QUEUE        12'h400
`define A_QUEUE_END    12'h4FF
`define A_TABLE        12'h800
`define A_TABLE_END    12'hBFF

`define SCHED_EN_BIT   31
`define ZLP_FLAG_BIT   19
`define IRQ_Q_FIRST    6'h18
`define IRQ_Q_LAST     6'h1B
`define TX_FIELDS      3'h5
`define RX_FIELDS      2'h3
`define LINK_BYTES     32'h4
`define EMPTY_IDX      16'hFFFF
`define MAX_DESC       65536

`endif

// ==== rtl/usb_dma_pkg.sv ====
// Types shared by the packet DMA block and its bench.
`default_nettype none
package usb_dma_pkg;

  typedef enum logic [2:0] {
    AR_CTRL, AR_REGION, AR_TX, AR_RX, AR_QUEUE, AR_TABLE, AR_NONE
  } area_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic       dir;
  } credit_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] count;
    logic [31:0] info2;
  } block_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] len;
  } usb_pkt_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  queue;
    logic [15:0] desc;
  } compl_t;

  typedef struct packed {
    logic [7:0]             idx;
    logic                   en;
    logic [8:0]             size;
    credit_t                credit;
    logic [7:0]             ch_en;
    logic [15:0][31:0]      rg_base;
    logic [15:0][15:0]      rg_first;
    logic [15:0][15:0]      rg_size;
    logic [31:0]            link_base0;
    logic [31:0]            link_base1;
    logic [15:0]            link0_count;
    logic [15:0]            probe;
    logic [3:0][4:0][31:0]  tx_rec;
    logic [3:0][2:0][31:0]  rx_rec;
    logic [63:0]            qvalid;
    compl_t                 hold;
    logic                   ready;
    logic                   irq;
    logic [31:0]            rdata;
    block_t                 block;
    usb_pkt_t               close;
    usb_pkt_t               usb_tx;
  } state_t;

endpackage

`default_nettype wire

// ==== rtl/usb_packet_dma_scheduler.sv ====
// Queue manager, credit scheduler and zero-length handling of the USB DMA.
//
// Operation
// - Up to sixteen descriptor regions, each with one programmable size.
// - Descriptors are named by a 16-bit index, at most 64K in all.
// - One link entry per index, contiguous per region; host gives first index.
// - Two link stores with free placement serve all regions.
// - Zero-length receive packet yields a zero-count block with zero flag set.
// - A zero-flagged block closes the packet normally and moves no data.
// - Zero-flagged transmit ignores the packet size and sends zero length.
// - Table of up to 256 entries, each a channel and direction bit.
// - Table is write-only; reads return no contents.
// - Host-programmed size field limits the table.
// - Scheduler runs only once enabled; table rewrites allowed while running.
// - On enable the scheduler starts at index zero.
// - Entry eligible when channel enabled and FIFO not full or not empty.
// - Eligible entry offers a credit and stalls until it is accepted.
// - Advance after acceptance, or at once when the entry is not eligible.
// - Index wraps to zero when it would reach the table size.
// - Completion interrupt goes out directly with no mask.
// - Interrupt on completion to queues 24 to 27 only.
// - Four transmit records of five words each, two head and two completion pointers among them.
// - Four receive records with head, completion pointer and buffer offset.
// - Push appends at the tail; pop returns the head and advances it.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "usb_dma_map.svh"

module usb_packet_dma_scheduler #(
  parameter int LINK_DEPTH = `MAX_DESC
) (
  // Clock and reset.
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Register port.
  input  wire logic [11:0]           reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output var  logic [31:0]           reg_rdata_out,
  // Scheduling interface.
  input  wire logic [3:0]            tx_fifo_full_in,
  input  wire logic [3:0]            rx_fifo_empty_in,
  input  wire logic                  credit_accept_in,
  output var  usb_dma_pkg::credit_t  credit_out,
  // Completion pushes and interrupt.
  input  wire usb_dma_pkg::compl_t   compl_in,
  output var  logic                  compl_ready_out,
  output var  logic                  irq_out,
  // Receive and transmit packet paths.
  input  wire usb_dma_pkg::usb_pkt_t usb_rx_in,
  output var  usb_dma_pkg::block_t   block_out,
  output var  usb_dma_pkg::usb_pkt_t pkt_done_out,
  input  wire usb_dma_pkg::block_t   tx_desc_in,
  output var  usb_dma_pkg::usb_pkt_t usb_tx_out
);
  import usb_dma_pkg::*;

  localparam int LAW = $clog2(LINK_DEPTH);

  generate
    if (LINK_DEPTH < 2 || LINK_DEPTH > `MAX_DESC ||
        (1 << LAW) != LINK_DEPTH) begin : g_bad_depth
      $error("LINK_DEPTH must be a power of two up to 65536");
    end
  endgenerate

  state_t      s_q;
  state_t      s_d;
  logic [2:0]  table_q [256];
  logic [15:0] link_mem [LINK_DEPTH];
  logic [15:0] head_mem [64];
  logic [15:0] tail_mem [64];

  area_t       area;
  logic        tbl_we;
  logic        op_push;
  logic        op_pop;
  logic [5:0]  op_q;
  logic [15:0] op_desc;
  logic [15:0] q_head;
  logic [15:0] q_tail;
  logic [2:0]  ent;
  logic        elig;

  function automatic area_t decode(input logic [11:0] a);
    if (a <= `A_LINK0_COUNT) begin
      return AR_CTRL;
    end else if (a >= `A_REGION && a <= `A_REGION_END) begin
      return AR_REGION;
    end else if (a >= `A_TXREC && a <= `A_TXREC_END) begin
      return AR_TX;
    end else if (a >= `A_RXREC && a <= `A_RXREC_END) begin
      return AR_RX;
    end else if (a >= `A_QUEUE && a <= `A_QUEUE_END) begin
      return AR_QUEUE;
    end else if (a >= `A_TABLE && a <= `A_TABLE_END) begin
      return AR_TABLE;
    end
    return AR_NONE;
  endfunction

  // Next table index, wrapping at the programmed size.
  function automatic logic [7:0] next_idx(input logic [7:0] i,
                                          input logic [8:0] size);
    logic [8:0] n;
    n = {1'b0, i} + 9'h001;
    return (n >= size) ? 8'h00 : n[7:0];
  endfunction

  // Address of a descriptor from the region that holds its index.
  function automatic logic [31:0] desc_addr(input state_t s,
                                            input logic [15:0] idx);
    logic [31:0] a;
    logic [15:0] best;
    logic        found;
    a = 32'h0000_0000;
    best = 16'h0000;
    found = 1'b0;
    for (int r = 0; r < 16; r++) begin
      if (s.rg_size[r] != 16'h0000 && s.rg_first[r] <= idx &&
          (!found || s.rg_first[r] >= best)) begin
        found = 1'b1;
        best = s.rg_first[r];
        a = s.rg_base[r] +
            32'(idx - s.rg_first[r]) * 32'(s.rg_size[r]);
      end
    end
    return a;
  endfunction

  // Link entry address, split over the two link stores.
  function automatic logic [31:0] link_addr(input state_t s,
                                            input logic [15:0] idx);
    if (idx < s.link0_count) begin
      return s.link_base0 + 32'(idx) * `LINK_BYTES;
    end
    return s.link_base1 + 32'(idx - s.link0_count) * `LINK_BYTES;
  endfunction

  assign area   = decode(reg_addr_in);
  assign tbl_we = reg_wr_in && area == AR_TABLE;
  assign ent    = table_q[s_q.idx];
  assign q_head = head_mem[op_q];
  assign q_tail = tail_mem[op_q];

  // Channel is eligible when enabled and its FIFO can take part.
  assign elig = ent[2] ? (s_q.ch_en[4 + ent[1:0]] &&
                          !rx_fifo_empty_in[ent[1:0]])
                       : (s_q.ch_en[ent[1:0]] &&
                          !tx_fifo_full_in[ent[1:0]]);

  // Host queue access wins; a held completion push waits for a free cycle.
  always_comb begin
    op_push = 1'b0;
    op_pop  = 1'b0;
    op_q    = reg_addr_in[7:2];
    op_desc = reg_wdata_in[15:0];
    if (area == AR_QUEUE && (reg_wr_in || reg_rd_in)) begin
      op_push = reg_wr_in;
      op_pop  = reg_rd_in;
    end else if (s_q.hold.valid) begin
      op_push = 1'b1;
      op_q    = s_q.hold.queue;
      op_desc = s_q.hold.desc;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rdata = 32'h0000_0000;
    s_d.block.valid = 1'b0;
    s_d.close.valid = 1'b0;
    s_d.usb_tx.valid = 1'b0;

    if (reg_wr_in) begin
      unique case (area)
        AR_CTRL: begin
          unique case (reg_addr_in)
            `A_SCHED_CTRL: begin
              s_d.en   = reg_wdata_in[`SCHED_EN_BIT];
              s_d.size = reg_wdata_in[8:0];
            end
            `A_CH_EN:       s_d.ch_en = reg_wdata_in[7:0];
            `A_PROBE:       s_d.probe = reg_wdata_in[15:0];
            `A_LINK_BASE0:  s_d.link_base0 = reg_wdata_in;
            `A_LINK_BASE1:  s_d.link_base1 = reg_wdata_in;
            `A_LINK0_COUNT: s_d.link0_count = reg_wdata_in[15:0];
            default: ;
          endcase
        end
        AR_REGION: begin
          if (reg_addr_in[2]) begin
            s_d.rg_first[reg_addr_in[6:3]] = reg_wdata_in[15:0];
            s_d.rg_size[reg_addr_in[6:3]] = reg_wdata_in[31:16];
          end else begin
            s_d.rg_base[reg_addr_in[6:3]] = reg_wdata_in;
          end
        end
        AR_TX: begin
          if (reg_addr_in[4:2] < `TX_FIELDS) begin
            s_d.tx_rec[reg_addr_in[6:5]][reg_addr_in[4:2]] =
              reg_wdata_in;
          end
        end
        AR_RX: begin
          if (reg_addr_in[3:2] < `RX_FIELDS) begin
            s_d.rx_rec[reg_addr_in[5:4]][reg_addr_in[3:2]] =
              reg_wdata_in;
          end
        end
        AR_QUEUE, AR_TABLE, AR_NONE: ;
      endcase
    end

    if (reg_rd_in) begin
      unique case (area)
        AR_CTRL: begin
          unique case (reg_addr_in)
            `A_SCHED_CTRL:  s_d.rdata = {s_q.en, 22'h0, s_q.size};
            `A_CH_EN:       s_d.rdata = {24'h0, s_q.ch_en};
            `A_STATUS: begin
              s_d.rdata = {23'h0, s_q.credit.valid, s_q.idx};
            end
            `A_PROBE:       s_d.rdata = {16'h0, s_q.probe};
            `A_DESC_ADDR:   s_d.rdata = desc_addr(s_q, s_q.probe);
            `A_LINK_ADDR:   s_d.rdata = link_addr(s_q, s_q.probe);
            `A_LINK_BASE0:  s_d.rdata = s_q.link_base0;
            `A_LINK_BASE1:  s_d.rdata = s_q.link_base1;
            `A_LINK0_COUNT: s_d.rdata = {16'h0, s_q.link0_count};
            default: ;
          endcase
        end
        AR_REGION: begin
          s_d.rdata = reg_addr_in[2] ?
            {s_q.rg_size[reg_addr_in[6:3]], s_q.rg_first[reg_addr_in[6:3]]} :
            s_q.rg_base[reg_addr_in[6:3]];
        end
        AR_TX: begin
          if (reg_addr_in[4:2] < `TX_FIELDS) begin
            s_d.rdata = s_q.tx_rec[reg_addr_in[6:5]][reg_addr_in[4:2]];
          end
        end
        AR_RX: begin
          if (reg_addr_in[3:2] < `RX_FIELDS) begin
            s_d.rdata = s_q.rx_rec[reg_addr_in[5:4]][reg_addr_in[3:2]];
          end
        end
        AR_QUEUE: begin
          s_d.rdata = {16'h0, s_q.qvalid[op_q] ? q_head : `EMPTY_IDX};
        end
        AR_TABLE: s_d.rdata = 32'h0000_0000;
        AR_NONE: ;
      endcase
    end

    // Queue bookkeeping; pop empties a queue holding one entry.
    if (op_pop && s_q.qvalid[op_q] && q_head == q_tail) begin
      s_d.qvalid[op_q] = 1'b0;
    end
    if (op_push) begin
      s_d.qvalid[op_q] = 1'b1;
    end
    if (op_push && !(area == AR_QUEUE && (reg_wr_in || reg_rd_in))) begin
      s_d.hold.valid = 1'b0;
      s_d.irq = op_q >= `IRQ_Q_FIRST && op_q <= `IRQ_Q_LAST;
    end
    if (compl_in.valid && s_q.ready) begin
      s_d.hold = compl_in;
    end
    s_d.ready = !s_d.hold.valid;

    // Credit scheduler.
    if (!s_q.en) begin
      s_d.idx = 8'h00;
      s_d.credit.valid = 1'b0;
    end else if (s_q.credit.valid) begin
      if (credit_accept_in) begin
        s_d.credit.valid = 1'b0;
        s_d.idx = next_idx(s_q.idx, s_q.size);
      end
    end else if (elig) begin
      s_d.credit = '{valid: 1'b1, chan: ent[1:0], dir: ent[2]};
    end else begin
      s_d.idx = next_idx(s_q.idx, s_q.size);
    end

    // Receive blocks: zero length sets the zero-byte flag.
    if (usb_rx_in.valid) begin
      s_d.block.valid = 1'b1;
      s_d.block.count = usb_rx_in.len;
      s_d.block.info2 = 32'h0000_0000;
      s_d.block.info2[`ZLP_FLAG_BIT] = usb_rx_in.len == 16'h0000;
    end
    if (s_q.block.valid) begin
      s_d.close.valid = 1'b1;
      s_d.close.len = s_q.block.info2[`ZLP_FLAG_BIT] ? 16'h0000
                                                     : s_q.block.count;
    end

    // Transmit: zero-byte flag overrides the descriptor size.
    if (tx_desc_in.valid) begin
      s_d.usb_tx.valid = 1'b1;
      s_d.usb_tx.len = tx_desc_in.info2[`ZLP_FLAG_BIT] ? 16'h0000
                                                       : tx_desc_in.count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Table, link store and queue pointer memories.
  always_ff @(posedge clk_in) begin
    if (rst_n_in && tbl_we) begin
      table_q[reg_addr_in[9:2]] <= reg_wdata_in[2:0];
    end
    if (rst_n_in && op_push) begin
      if (s_q.qvalid[op_q]) begin
        link_mem[q_tail[LAW-1:0]] <= op_desc;
      end else begin
        head_mem[op_q] <= op_desc;
      end
      tail_mem[op_q] <= op_desc;
    end
    if (rst_n_in && op_pop && s_q.qvalid[op_q]) begin
      head_mem[op_q] <= link_mem[q_head[LAW-1:0]];
    end
  end

  assign reg_rdata_out   = s_q.rdata;
  assign credit_out      = s_q.credit;
  assign compl_ready_out = s_q.ready;
  assign irq_out         = s_q.irq;
  assign block_out       = s_q.block;
  assign pkt_done_out    = s_q.close;
  assign usb_tx_out      = s_q.usb_tx;

endmodule // usb_packet_dma_scheduler

`default_nettype wire

// ==== tb/sched_properties.sv ====
// Concurrent checks on the ports of the USB packet DMA scheduler.
`timescale 1ns/100ps
`default_nettype none
module sched_properties
  import usb_dma_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Register port.
  input wire logic [11:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Scheduling.
  input wire logic [3:0]  tx_fifo_full_in,
  input wire logic [3:0]  rx_fifo_empty_in,
  input wire logic        credit_accept_in,
  input wire credit_t     credit_out,
  // Completions.
  input wire compl_t      compl_in,
  input wire logic        compl_ready_out,
  input wire logic        irq_out,
  // Packet paths.
  input wire usb_pkt_t    usb_rx_in,
  input wire block_t      block_out,
  input wire usb_pkt_t    pkt_done_out,
  input wire block_t      tx_desc_in,
  input wire usb_pkt_t    usb_tx_out
);
  logic [3:0] full_q;
  logic [3:0] empty_q;
  always_ff @(posedge clk_in) begin
    full_q  <= tx_fifo_full_in;
    empty_q <= rx_fifo_empty_in;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_offer;
    credit_out.valid && !credit_accept_in &&
      !(reg_wr_in && reg_addr_in == 12'h000) &&
      !$past(reg_wr_in && reg_addr_in == 12'h000);
  endsequence
  sequence s_taken;
    credit_out.valid && credit_accept_in;
  endsequence
  sequence s_zero_rx;
    usb_rx_in.valid && usb_rx_in.len == 16'h0000;
  endsequence
  sequence s_irq_push;
    compl_in.valid && compl_ready_out &&
      compl_in.queue >= 6'h18 && compl_in.queue <= 6'h1B;
  endsequence
  a_credit_hold:
    assert property (s_offer |=> credit_out.valid && $stable(credit_out))
    else $error("credit dropped before acceptance");
  a_credit_drop:
    assert property (s_taken |=> !credit_out.valid)
    else $error("credit stayed after acceptance");
  a_credit_elig:
    assert property ($rose(credit_out.valid) |-> !(credit_out.dir ?
      empty_q[credit_out.chan] : full_q[credit_out.chan]))
    else $error("credit offered to ineligible channel");
  a_irq_after:
    assert property (s_irq_push |-> ##[2:8] irq_out)
    else $error("no interrupt for reserved completion queue");
  a_irq_pulse:
    assert property (irq_out |=> !irq_out)
    else $error("interrupt longer than one cycle");
  a_zero_close:
    assert property (s_zero_rx |=> block_out.valid &&
      block_out.count == 16'h0000 && block_out.info2 == 32'h0008_0000
      ##1 pkt_done_out.valid && pkt_done_out.len == 16'h0000)
    else $error("zero packet not closed as zero");
  a_close_len:
    assert property (block_out.valid |=> pkt_done_out.valid &&
      pkt_done_out.len == $past(block_out.count))
    else $error("close length differs from block count");
  a_tx_zero:
    assert property (tx_desc_in.valid && tx_desc_in.info2[19] |=>
      usb_tx_out.valid && usb_tx_out.len == 16'h0000)
    else $error("flagged transmit not zero length");
  a_table_read:
    assert property (reg_rd_in && reg_addr_in >= 12'h800 &&
      reg_addr_in <= 12'hBFF |=> reg_rdata_out == 32'h0000_0000)
    else $error("table read returned contents");
endmodule // sched_properties
bind usb_packet_dma_scheduler sched_properties u_props (
  .clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .tx_fifo_full_in, .rx_fifo_empty_in,
  .credit_accept_in, .credit_out, .compl_in, .compl_ready_out,
  .irq_out, .usb_rx_in, .block_out, .pkt_done_out, .tx_desc_in,
  .usb_tx_out
);
`default_nettype wire

// ==== tb/dma_ctrl_model.sv ====
// Behavioural model of the packet DMA controller that takes credits.
`timescale 1ns/100ps
`default_nettype none
module dma_ctrl_model
  import usb_dma_pkg::*;
(
  input wire logic    clk_in,
  input wire logic    rst_n_in,
  input wire credit_t credit_in,
  output var logic    accept_out
);
  int unsigned busy;
  // Credits are taken only when idle; a random busy spell follows.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      accept_out <= 1'b0;
      busy <= 0;
    end else if (busy != 0) begin
      accept_out <= 1'b0;
      busy <= busy - 1;
    end else if (credit_in.valid && !accept_out) begin
      accept_out <= 1'b1;
      busy <= $urandom_range(3, 0);
    end else begin
      accept_out <= 1'b0;
    end
  end
endmodule // dma_ctrl_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the USB packet DMA scheduler.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import usb_dma_pkg::*;
  logic        clk_in, rst_n_in, wr, rd, accept, ready, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  full, empty;
  credit_t     credit;
  compl_t      compl;
  usb_pkt_t    usb_rx, done, usb_tx;
  block_t      blk, tx_desc;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [2:0]  got[$];
  logic [2:0]  exp_q[$];

  usb_packet_dma_scheduler #(.LINK_DEPTH(256)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .tx_fifo_full_in(full),
    .rx_fifo_empty_in(empty), .credit_accept_in(accept),
    .credit_out(credit), .compl_in(compl), .compl_ready_out(ready),
    .irq_out(irq), .usb_rx_in(usb_rx), .block_out(blk),
    .pkt_done_out(done), .tx_desc_in(tx_desc), .usb_tx_out(usb_tx));
  dma_ctrl_model partner (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .credit_in(credit), .accept_out(accept));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (credit.valid === 1'b1 && accept === 1'b1)
      got.push_back({credit.dir, credit.chan});
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic wr_reg(logic [11:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(logic [11:0] a, logic [31:0] e, string n);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
    @(posedge clk_in);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic sched_round(logic [7:0] en, int sz);
    logic [2:0] e;
    exp_q.delete();
    full <= 4'($urandom());
    empty <= 4'($urandom());
    wr_reg(12'h004, {24'h0, en});
    for (int i = 0; i < sz; i++) begin
      e = 3'($urandom());
      wr_reg(12'h800 + 12'(4 * i), {29'h0, e});
      if (e[2] ? !empty[e[1:0]] && en[4 + e[1:0]]
               : !full[e[1:0]] && en[e[1:0]])
        exp_q.push_back(e);
    end
    got.delete();
    wr_reg(12'h000, 32'h8000_0000 | sz);
    for (int c = 0; c < 300 && got.size() < 6; c++) @(posedge clk_in);
    if (exp_q.size() == 0) chk("credits", 0, got.size());
    else for (int k = 0; k < 6; k++)
      chk("credit", exp_q[k % exp_q.size()], got[k]);
    wr_reg(12'h000, 32'h0000_0004);
    repeat (3) @(posedge clk_in);
    rd_reg(12'h008, 0, "status");
  endtask

  task automatic push_done(logic [5:0] q);
    logic hit;
    hit = 1'b0;
    compl <= {1'b1, q, 16'h0100 + 16'(q)};
    @(posedge clk_in);
    compl <= '0;
    #1 chk("ready", 0, ready);
    for (int c = 0; c < 6; c++) begin
      @(posedge clk_in);
      #1 if (irq === 1'b1) hit = 1'b1;
    end
    chk("irq", q >= 24 && q <= 27, hit);
    @(posedge clk_in);
  endtask

  initial begin
    int p;
    void'($urandom(85));
    {rst_n_in, wr, rd, addr, wdata, full, empty} = '0;
    {compl, usb_rx, tx_desc} = '0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd_reg(12'h008, 0, "status");
    rd_reg(12'h800, 0, "table");
    rd_reg(12'h0F0, 0, "unmapped");
    $display("test reset done");
    for (int r = 0; r < 5; r++)
      sched_round(r == 0 ? 8'h00 : 8'($urandom()), r % 2 ? 3 : 4);
    $display("test scheduler done");
    wr_reg(12'h100, 32'h0000_1000);
    wr_reg(12'h104, 32'h0040_0000);
    wr_reg(12'h108, 32'h0000_8000);
    wr_reg(12'h10C, 32'h0020_0010);
    wr_reg(12'h018, 32'h100);
    wr_reg(12'h01C, 32'h200);
    wr_reg(12'h020, 32'hA);
    p = $urandom();
    wr_reg(12'h270, p);
    rd_reg(12'h270, p, "tx record");
    rd_reg(12'h274, 0, "tx spare");
    wr_reg(12'h328, ~p);
    rd_reg(12'h328, ~p, "rx record");
    for (int k = 0; k < 3; k++) begin
      p = $urandom_range(31, 0);
      wr_reg(12'h00C, p);
      rd_reg(12'h010, p < 16 ? 4096 + p * 64 : 32768 + (p - 16) * 32,
             "desc addr");
      rd_reg(12'h014, p < 10 ? 256 + 4 * p : 512 + 4 * (p - 10),
             "link addr");
    end
    $display("test regions done");
    for (int k = 0; k < 4; k++) begin
      p = k[0] ? $urandom_range(512, 1) : 0;
      usb_rx <= {1'b1, 16'(p)};
      tx_desc <= {1'b1, 16'(p + 1), 12'h0, k[1], 19'h0};
      @(posedge clk_in);
      usb_rx <= '0;
      tx_desc <= '0;
      #1 chk("block count", p, blk.count);
      chk("zero flag", p == 0 ? 32'h0008_0000 : 0, blk.info2);
      chk("tx len", k[1] ? 0 : p + 1, usb_tx.len);
      @(posedge clk_in);
      #1 chk("close", {1'b1, 16'(p)}, done);
      @(posedge clk_in);
    end
    $display("test packets done");
    for (int q = 23; q < 29; q++) push_done(6'(q));
    for (int q = 23; q < 29; q++)
      rd_reg(12'h400 + 12'(4 * q), 32'h100 + q, "pop");
    wr_reg(12'h478, 32'h0000_0011);
    wr_reg(12'h478, 32'h0000_0022);
    rd_reg(12'h478, 32'h11, "pop first");
    rd_reg(12'h478, 32'h22, "pop second");
    rd_reg(12'h478, 32'hFFFF, "pop empty");
    $display("test queues done");
    close_out();
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    num_errors++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
